// File: logic/sifm_input_mapper.sv
/*
 * Servo drive discrete input mapper: pin sync, function mapping, monitor, irq.
 * Assumes asynchronous pins (1 = ON) and a one-cycle register strobe master.
 */
// Functional notes
// - Assign mode 0: pin functions come only from the control mode table.
// - Control mode accepts 0 to 11; larger writes are refused and flagged.
// - Fixed mode 10: one pin zero clamp, another torque limit switching.
// - Fixed mode 11: one pin drives command pulse inhibit.
// - Assign mode 1 (default): each pin uses its own function code.
// - Function codes reset to documented defaults per pin.
// - Function numbers select servo on, limits, alarm clear and others.
// - Adding 0x100 to a code inverts that function's active sense.
// - Travel limits active when OFF; other functions active when ON.
// - Code 0x102 releases the forward limit while input is OFF.
// - Three forced codes keep their functions permanently active.
// - Same function on several pins raises the parameter error alarm.
// - Monitor order: pins 40,41,42,43,44,45,46,39,38; OFF and ON shown.
// - Monitor read returns a word; 0x1FE means only servo enable ON.
`timescale 1ns/100ps
`include "sifm_cfg.svh"
module sifm_input_mapper
    import sifm_pkg::*;
#(
    parameter int NPIN = `SIFM_NPIN
)
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [NPIN-1:0]   pin_on_i,
    input  wire logic [15:0]       addr_i,
    input  wire logic [15:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [15:0]       rdata_o,
    output sifm_fvec_t             func_active_o,
    output logic                   param_err_o,
    output logic                   irq_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic       [NPIN-1:0]   pin_meta_ff;
    logic       [NPIN-1:0]   pin_sync_ff;
    logic       [NPIN-1:0]   pin_prev_ff;
    logic                    assign_mode_ff;
    logic       [3:0]        ctrl_mode_ff;
    sifm_code_t              code_ff   [NPIN];
    sifm_code_t              force_ff  [`SIFM_NFORCE];
    sifm_code_t              eff_code  [NPIN];
    sifm_fvec_t              dec_sel   [NPIN];
    sifm_fvec_t              dec_func  [NPIN];
    sifm_fvec_t              forced_w;
    sifm_fvec_t              nxt_func;
    sifm_fvec_t              func_ff;
    logic                    dup_w;
    logic                    err_ff;
    logic                    bad_mode_w;
    logic       [2:0]        irq_sts_ff;
    logic       [2:0]        irq_msk_ff;
    logic       [2:0]        irq_evt_w;
    logic       [15:0]       nxt_rdata;
    logic       [15:0]       rdata_ff;
    logic       [15:0]       mon_w;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two stages before any logic looks at the pins
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            pin_prev_ff <= '0;
        end
        else if (ce_i)
        begin
            pin_meta_ff <= pin_on_i;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    assign bad_mode_w = wr_i && (addr_i == `SIFM_OFS_MODE) && (wdata_i[15:0] > 16'(`SIFM_MODE_MAX));

    // Assignment mode and control mode
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            assign_mode_ff <= `SIFM_RST_ASSIGN;
            ctrl_mode_ff   <= `SIFM_RST_MODE;
        end
        else if (ce_i && wr_i)
        begin
            if (addr_i == `SIFM_OFS_ASSIGN)
            begin
                assign_mode_ff <= wdata_i[0];
            end
            if ((addr_i == `SIFM_OFS_MODE) && !bad_mode_w)
            begin
                ctrl_mode_ff <= wdata_i[3:0];
            end
        end
    end

    // Per-pin codes and forced-active codes
    generate
        for (genvar gi = 0; gi < NPIN; gi++)
        begin : g_code
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                begin
                    code_ff[gi] <= 9'(`SIFM_RST_CODES >> (9 * gi));
                end
                else if (ce_i && wr_i && (addr_i == `SIFM_OFS_CODE0 + 16'(gi)))
                begin
                    code_ff[gi] <= wdata_i[8:0];
                end
            end
        end
        for (genvar gf = 0; gf < `SIFM_NFORCE; gf++)
        begin : g_force
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                begin
                    force_ff[gf] <= '0;
                end
                else if (ce_i && wr_i && (addr_i == `SIFM_OFS_FORCE0 + 16'(gf)))
                begin
                    force_ff[gf] <= wdata_i[8:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Function mapping
    // ----------------------------------------------------------------
    // Code source chosen by assignment mode, then decoded per pin
    generate
        for (genvar gp = 0; gp < NPIN; gp++)
        begin : g_pin
            assign eff_code[gp] = assign_mode_ff ? code_ff[gp]
                                                 : fixed_code(ctrl_mode_ff, 4'(gp));
            sifm_pin_decode u_dec
            (
                .code_i   (eff_code[gp]),
                .pin_on_i (pin_sync_ff[gp]),
                .sel_o    (dec_sel[gp]),
                .func_o   (dec_func[gp])
            );
        end
    endgenerate

    // Forced functions, pin contributions and duplicate detection
    always_comb
    begin
        sifm_fvec_t seen;
        seen     = '0;
        dup_w    = 1'b0;
        forced_w = '0;
        for (int f = 0; f < `SIFM_NFORCE; f++)
        begin
            forced_w = forced_w | sifm_onehot(force_ff[f][7:0]);
        end
        nxt_func = forced_w;
        for (int p = 0; p < NPIN; p++)
        begin
            dup_w    = dup_w | (|(seen & dec_sel[p]));
            seen     = seen | dec_sel[p];
            nxt_func = nxt_func | dec_func[p];
        end
    end

    // Registered function states and error level
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            func_ff <= '0;
            err_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            func_ff <= nxt_func;
            err_ff  <= dup_w;
        end
    end

    assign func_active_o = func_ff;
    assign param_err_o   = err_ff;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // Events: new parameter error, refused mode write, input change
    assign irq_evt_w = {(pin_sync_ff != pin_prev_ff), bad_mode_w, (dup_w && !err_ff)};

    // Sticky status, write one to clear, set wins over clear
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            irq_sts_ff <= '0;
            irq_msk_ff <= '0;
        end
        else if (ce_i)
        begin
            irq_sts_ff <= (irq_sts_ff & ~((wr_i && (addr_i == `SIFM_OFS_IRQ_STS)) ? wdata_i[2:0] : 3'h0))
                          | irq_evt_w;
            if (wr_i && (addr_i == `SIFM_OFS_IRQ_MSK))
            begin
                irq_msk_ff <= wdata_i[2:0];
            end
        end
    end

    assign irq_o = |(irq_sts_ff & irq_msk_ff);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Monitor word: bit n-1 is position n, 1 means OFF
    assign mon_w = {7'h00, ~pin_sync_ff};

    always_comb
    begin
        case (addr_i)
            `SIFM_OFS_MON:     nxt_rdata = mon_w;
            `SIFM_OFS_ASSIGN:  nxt_rdata = {15'h0000, assign_mode_ff};
            `SIFM_OFS_MODE:    nxt_rdata = {12'h000, ctrl_mode_ff};
            `SIFM_OFS_IRQ_STS: nxt_rdata = {13'h0000, irq_sts_ff};
            `SIFM_OFS_IRQ_MSK: nxt_rdata = {13'h0000, irq_msk_ff};
            `SIFM_OFS_FUNC:    nxt_rdata = func_ff[15:0];
            default:           nxt_rdata = 16'h0000;
        endcase
        for (int i = 0; i < NPIN; i++)
        begin
            if (addr_i == `SIFM_OFS_CODE0 + 16'(i))
            begin
                nxt_rdata = {7'h00, code_ff[i]};
            end
        end
        for (int i = 0; i < `SIFM_NFORCE; i++)
        begin
            if (addr_i == `SIFM_OFS_FORCE0 + 16'(i))
            begin
                nxt_rdata = {7'h00, force_ff[i]};
            end
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= '0;
        end
        else if (ce_i)
        begin
            rdata_ff <= rd_i ? nxt_rdata : 16'h0000;
        end
    end

    assign rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_fixed_servo;
        @(posedge mclk_i) disable iff (rst_i)
        !assign_mode_ff |-> (eff_code[0] == 9'h001) && (eff_code[8] == 9'h000);
    endproperty
    a_fixed_servo: assert property (p_fixed_servo) else $error("fixed map wrong on pin 40");

    property p_mode_range;
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && bad_mode_w |=> $stable(ctrl_mode_ff) && irq_sts_ff[1];
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("illegal mode accepted");

    property p_pos_map;
        @(posedge mclk_i) disable iff (rst_i)
        !assign_mode_ff && (ctrl_mode_ff == 4'h0)
            |-> (eff_code[1] == 9'h005) && (eff_code[5] == 9'h006) && (eff_code[6] == 9'h000);
    endproperty
    a_pos_map: assert property (p_pos_map) else $error("position mode map wrong");

    property p_zero_speed_clamp_map;
        @(posedge mclk_i) disable iff (rst_i)
        !assign_mode_ff && (ctrl_mode_ff == 4'hA) |-> (eff_code[1] == 9'h00C) && (eff_code[5] == 9'h006);
    endproperty
    a_zero_speed_clamp_map: assert property (p_zero_speed_clamp_map) else $error("zero clamp map wrong");

    property p_inhibit_map;
        @(posedge mclk_i) disable iff (rst_i)
        !assign_mode_ff && (ctrl_mode_ff == 4'hB) |-> (eff_code[1] == 9'h00D);
    endproperty
    a_inhibit_map: assert property (p_inhibit_map) else $error("inhibit map wrong");

    property p_user_map;
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && assign_mode_ff && (code_ff[4] == 9'h004) && pin_sync_ff[4] |=> func_active_o[4];
    endproperty
    a_user_map: assert property (p_user_map) else $error("user code not applied");

    property p_reset_codes;
        @(posedge mclk_i)
        $fell(rst_i) |-> (code_ff[0] == 9'h001) && (code_ff[1] == 9'h005) && (code_ff[6] == 9'h007);
    endproperty
    a_reset_codes: assert property (p_reset_codes) else $error("code reset value wrong");

    property p_invert;
        @(posedge mclk_i) disable iff (rst_i)
        (eff_code[0] == 9'h101) && pin_sync_ff[0] |-> !dec_func[0][1];
    endproperty
    a_invert: assert property (p_invert) else $error("inverted servo on active");

    property p_limit_off;
        @(posedge mclk_i) disable iff (rst_i)
        (eff_code[3] == 9'h003) |-> (dec_func[3][3] == !pin_sync_ff[3]);
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("limit sense wrong");

    property p_fwd_release;
        @(posedge mclk_i) disable iff (rst_i)
        (eff_code[2] == 9'h102) && !pin_sync_ff[2] |-> !dec_func[2][2];
    endproperty
    a_fwd_release: assert property (p_fwd_release) else $error("forward limit not released");

    property p_forced;
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && (force_ff[0] == 9'h001) |=> func_active_o[1];
    endproperty
    a_forced: assert property (p_forced) else $error("forced servo on not active");

    property p_dup;
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && assign_mode_ff && (code_ff[0] == code_ff[2]) && (code_ff[0][7:0] == 8'h01) |=> param_err_o;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate code not flagged");

    property p_monitor;
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && rd_i && (addr_i == 16'hE100) |=> (rdata_o == {7'h00, ~$past(pin_sync_ff)});
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor word wrong");

    c_dup:     cover property (@(posedge mclk_i) disable iff (rst_i) $rose(param_err_o));
    c_irq:     cover property (@(posedge mclk_i) disable iff (rst_i) $rose(irq_o));
    c_zero_speed_clamp:  cover property (@(posedge mclk_i) disable iff (rst_i) !assign_mode_ff && func_active_o[12]);
    c_mon_rd:  cover property (@(posedge mclk_i) disable iff (rst_i) rd_i && (addr_i == 16'hE100));

endmodule : sifm_input_mapper

// File: logic/sifm_cfg.svh
/*
 * Constants of the servo input function mapper: offsets, fields, reset values.
 * Assumes inclusion by the package and the design files by bare name.
 */
`ifndef SIFM_CFG_SVH
`define SIFM_CFG_SVH

// ----------------------------------------------------------------
// Sizes and fields
// ----------------------------------------------------------------
`define SIFM_NPIN        9
`define SIFM_NFUNC       17
`define SIFM_NFORCE      3
`define SIFM_INV_BIT     8
`define SIFM_FN_VALID    17'h17F7E
`define SIFM_MODE_MAX    4'hB

// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define SIFM_FN_NONE     8'h00
`define SIFM_FN_SRV_ON   8'h01
`define SIFM_FN_FWD_LIM  8'h02
`define SIFM_FN_REV_LIM  8'h03
`define SIFM_FN_ALM_CLR  8'h04
`define SIFM_FN_P_CTRL   8'h05
`define SIFM_FN_TRQ_LIM  8'h06
`define SIFM_FN_RSVD     8'h07
`define SIFM_FN_SPD_DIR  8'h08
`define SIFM_FN_INTERNAL_SPEED_SELECT_A    8'h09
`define SIFM_FN_INTERNAL_SPEED_SELECT_B    8'h0A
`define SIFM_FN_MODE_SEL 8'h0B
`define SIFM_FN_ZERO_SPEED_CLAMP   8'h0C
`define SIFM_FN_INHIBIT  8'h0D

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SIFM_OFS_ASSIGN  16'hE000
`define SIFM_OFS_MODE    16'hE001
`define SIFM_OFS_CODE0   16'hE002
`define SIFM_OFS_FORCE0  16'hE00B
`define SIFM_OFS_IRQ_STS 16'hE010
`define SIFM_OFS_IRQ_MSK 16'hE011
`define SIFM_OFS_FUNC    16'hE012
`define SIFM_OFS_MON     16'hE100

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SIFM_RST_ASSIGN  1'h1
`define SIFM_RST_MODE    4'h0
`define SIFM_RST_CODES   {9'h000, 9'h000, 9'h007, 9'h006, 9'h004, 9'h003, 9'h002, 9'h005, 9'h001}

`endif

// File: logic/sifm_pkg.sv
/*
 * Types and shared decoding of the servo input function mapper.
 * Assumes the constants header is on the include path.
 */
package sifm_pkg;
`include "sifm_cfg.svh"

    typedef logic [8:0]              sifm_code_t;
    typedef logic [`SIFM_NFUNC-1:0]  sifm_fvec_t;

    typedef enum logic [3:0]
    {
        SIFM_MODE_POS      = 4'h0,
        SIFM_MODE_SPD      = 4'h1,
        SIFM_MODE_TRQ      = 4'h2,
        SIFM_MODE_ISPD     = 4'h3,
        SIFM_MODE_ISPD_SPD = 4'h4,
        SIFM_MODE_ISPD_POS = 4'h5,
        SIFM_MODE_ISPD_TRQ = 4'h6,
        SIFM_MODE_POS_SPD  = 4'h7,
        SIFM_MODE_POS_TRQ  = 4'h8,
        SIFM_MODE_TRQ_SPD  = 4'h9,
        SIFM_MODE_ZERO_SPEED_CLAMP   = 4'hA,
        SIFM_MODE_INHIBIT  = 4'hB
    } sifm_mode_e;

    // One-hot of a function number, zero for invalid or reserved codes
    function automatic sifm_fvec_t sifm_onehot(input logic [7:0] fn);
        sifm_fvec_t v;
        v = '0;
        if (fn < 8'(`SIFM_NFUNC))
        begin
            v = (sifm_fvec_t'(1) << fn[4:0]) & `SIFM_FN_VALID;
        end
        return v;
    endfunction : sifm_onehot

    // Fixed assignment table, indexed by monitor position
    function automatic sifm_code_t fixed_code(input logic [3:0] mode, input logic [3:0] pos);
        logic [7:0] fn;
        fn = `SIFM_FN_NONE;
        unique case (pos)
            4'h0:    fn = `SIFM_FN_SRV_ON;
            4'h2:    fn = `SIFM_FN_FWD_LIM;
            4'h3:    fn = `SIFM_FN_REV_LIM;
            4'h4:    fn = `SIFM_FN_ALM_CLR;
            4'h1:
            begin
                unique case (mode)
                    SIFM_MODE_POS, SIFM_MODE_SPD, SIFM_MODE_TRQ:            fn = `SIFM_FN_P_CTRL;
                    SIFM_MODE_ISPD, SIFM_MODE_ISPD_SPD, SIFM_MODE_ISPD_POS,
                    SIFM_MODE_ISPD_TRQ:                                     fn = `SIFM_FN_SPD_DIR;
                    SIFM_MODE_POS_SPD, SIFM_MODE_POS_TRQ, SIFM_MODE_TRQ_SPD: fn = `SIFM_FN_MODE_SEL;
                    SIFM_MODE_ZERO_SPEED_CLAMP:                                       fn = `SIFM_FN_ZERO_SPEED_CLAMP;
                    SIFM_MODE_INHIBIT:                                      fn = `SIFM_FN_INHIBIT;
                    default:                                                fn = `SIFM_FN_NONE;
                endcase
            end
            4'h5:
            begin
                if ((mode >= SIFM_MODE_ISPD) && (mode <= SIFM_MODE_ISPD_TRQ))
                begin
                    fn = `SIFM_FN_INTERNAL_SPEED_SELECT_A;
                end
                else if (mode <= `SIFM_MODE_MAX)
                begin
                    fn = `SIFM_FN_TRQ_LIM;
                end
            end
            4'h6:
            begin
                if ((mode >= SIFM_MODE_ISPD) && (mode <= SIFM_MODE_ISPD_TRQ))
                begin
                    fn = `SIFM_FN_INTERNAL_SPEED_SELECT_B;
                end
            end
            default: fn = `SIFM_FN_NONE; // Pins 39 and 38 ignored
        endcase
        return {1'b0, fn};
    endfunction : fixed_code

endpackage : sifm_pkg

// File: logic/sifm_pin_decode.sv
/*
 * Per-pin decoder: function code and pin level to selected and active function.
 * Assumes a synchronised pin level, 1 meaning the input is ON.
 */
`timescale 1ns/100ps
`include "sifm_cfg.svh"
module sifm_pin_decode
    import sifm_pkg::*;
(
    input  wire sifm_code_t code_i,
    input  wire logic       pin_on_i,
    output sifm_fvec_t      sel_o,
    output sifm_fvec_t      func_o
);

    logic lim_w;
    logic act_w;

    // Travel limits are active while OFF; invert bit flips the sense
    assign lim_w  = (code_i[7:0] == `SIFM_FN_FWD_LIM) || (code_i[7:0] == `SIFM_FN_REV_LIM);
    assign act_w  = (pin_on_i ^ lim_w) ^ code_i[`SIFM_INV_BIT];
    assign sel_o  = sifm_onehot(code_i[7:0]);
    assign func_o = act_w ? sel_o : '0;

endmodule : sifm_pin_decode

// File: dv/sifm_switch_model.sv
/*
 * Model of the external switches that drive the nine discrete inputs.
 * Assumes close_i is changed just after a rising clock edge by the bench.
 */
`timescale 1ns/100ps
module sifm_switch_model
(
    input  wire logic [8:0] close_i,
    output logic      [8:0] pin_on_o
);
    // An open switch leaves the pin pulled to OFF; a closed one grounds it to ON
    assign pin_on_o = close_i;
endmodule : sifm_switch_model

// File: dv/test_servo_input_function_mapper.sv
/*
 * Self-checking bench of the servo input function mapper.
 * Assumes the mapper package is compiled first and the clock enable stays high.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_servo_input_function_mapper
    import sifm_pkg::*;
;
    logic        mclk_i, rst_i, wr_i, rd_i;
    logic [15:0] addr_i, wdata_i, rdata_o;
    logic [8:0]  sw_close, pin_on;
    sifm_fvec_t  func_active_o;
    logic        param_err_o, irq_o;
    int          miscompares, comparisons;
    logic [15:0] rst_codes [9] = '{16'h0001, 16'h0005, 16'h0002, 16'h0003, 16'h0004,
                                   16'h0006, 16'h0007, 16'h0000, 16'h0000};
    logic [3:0]  fmodes [5] = '{4'h0, 4'h3, 4'h7, 4'hA, 4'hB};
    sifm_fvec_t  fbits [5] = '{17'h00020, 17'h00500, 17'h00800, 17'h01000, 17'h02000};
    sifm_fvec_t  tbits [5] = '{17'h00040, 17'h00200, 17'h00040, 17'h00040, 17'h00040};

    sifm_switch_model SW (.close_i(sw_close), .pin_on_o(pin_on));
    sifm_input_mapper #(.NPIN(9)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
        .pin_on_i(pin_on), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .func_active_o(func_active_o), .param_err_o(param_err_o), .irq_o(irq_o));

    // ----------------------------------------------------------------
    // Bus and pin helpers
    // ----------------------------------------------------------------
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask : rd

    // Apply a switch pattern and let it pass the sync stages
    task pins(input logic [8:0] p);
        @(posedge mclk_i);
        sw_close <= p;
        repeat (6) @(posedge mclk_i);
        #1;
    endtask : pins

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        for (int i = 0; i < 9; i++)
        begin
            rd(16'hE002 + 16'(i), rst_codes[i]);
        end
        rd(16'hE000, 16'h0001);
        rd(16'hE123, 16'h0000);
        pins(9'h000);
        rd(16'hE100, 16'h01FF);
        `CHK(func_active_o, 17'h0000C)
        $display("test reset done");
    endtask : t_reset

    task t_default;
        pins(9'h001);
        rd(16'hE100, 16'h01FE);
        `CHK(func_active_o, 17'h0000E)
        pins(9'h17E);
        rd(16'hE100, 16'h0081);
        `CHK(func_active_o, 17'h00070)
        $display("test default done");
    endtask : t_default

    task t_invert;
        wr(16'hE004, 16'h0102);
        wr(16'hE002, 16'h0101);
        pins(9'h000);
        `CHK(func_active_o, 17'h0000A)
        pins(9'h005);
        `CHK(func_active_o, 17'h0000C)
        wr(16'hE004, 16'h0002);
        wr(16'hE002, 16'h0001);
        $display("test invert done");
    endtask : t_invert

    task t_fixed;
        wr(16'hE000, 16'h0000);
        wr(16'hE003, 16'h0008);
        for (int i = 0; i < 5; i++)
        begin
            wr(16'hE001, {12'h000, fmodes[i]});
            pins(9'h1C2);
            `CHK(func_active_o, fbits[i] | 17'h0000C)
            pins(9'h020);
            `CHK(func_active_o, tbits[i] | 17'h0000C)
        end
        wr(16'hE010, 16'h0007);
        wr(16'hE001, 16'h000C);
        rd(16'hE001, 16'h000B);
        rd(16'hE010, 16'h0002);
        wr(16'hE001, 16'h000A);
        pins(9'h002);
        `CHK(func_active_o, 17'h0100C)
        wr(16'hE001, 16'h000B);
        pins(9'h002);
        `CHK(func_active_o, 17'h0200C)
        wr(16'hE003, 16'h0005);
        wr(16'hE000, 16'h0001);
        wr(16'hE001, 16'h0000);
        $display("test fixed done");
    endtask : t_fixed

    task t_forced;
        pins(9'h000);
        wr(16'hE00B, 16'h0001);
        wr(16'hE00C, 16'h000E);
        wr(16'hE00D, 16'h0010);
        pins(9'h000);
        `CHK(func_active_o, 17'h1400E)
        pins(9'h011);
        `CHK(func_active_o, 17'h1401E)
        rd(16'hE012, 16'h401E);
        wr(16'hE00B, 16'h0000);
        wr(16'hE00C, 16'h0000);
        wr(16'hE00D, 16'h0000);
        $display("test forced done");
    endtask : t_forced

    task t_dup;
        wr(16'hE011, 16'h0001);
        wr(16'hE010, 16'h0007);
        pins(9'h000);
        `CHK(irq_o, 1'b0)
        wr(16'hE004, 16'h0001);
        pins(9'h000);
        `CHK(param_err_o, 1'b1)
        `CHK(irq_o, 1'b1)
        wr(16'hE004, 16'h0002);
        pins(9'h000);
        `CHK(param_err_o, 1'b0)
        `CHK(irq_o, 1'b1)
        wr(16'hE010, 16'h0001);
        pins(9'h000);
        `CHK(irq_o, 1'b0)
        $display("test duplicate done");
    endtask : t_dup

    task test_done;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    initial
    begin
        {rst_i, wr_i, rd_i, addr_i, wdata_i, sw_close} = {2'b10, 1'b0, 32'h0, 9'h000};
        miscompares = 0;
        comparisons = 0;
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_default();
        t_invert();
        t_fixed();
        t_forced();
        t_dup();
        test_done();
    end

    // Cut a hang well past the expected few hundred cycles
    initial
    begin
        #2000000;
        miscompares++;
        test_done();
    end
endmodule : test_servo_input_function_mapper
